//--- hw/lmc_pkg.sv
`default_nettype none
package lmc_pkg;
    localparam int NPORT = 4;
    localparam int DW    = 32;
    localparam int CW    = 7;
    localparam int AW    = 32;
    localparam int BEW   = 4;
    localparam int RAW   = 5;

    // parity coverage masks
    // one mask per check bit, check bit 6 first
    localparam logic [CW-1:0][DW-1:0] CHK_MASK = {
        32'h2DA65CB7, 32'hFC000000, 32'h03FFF800, 32'h03FC07F0,
        32'hE3C3C78E, 32'h9B33366D, 32'h56AAAD5B
    };

    localparam logic [RAW-1:0] REG_STATUS  = 5'h00;
    localparam logic [RAW-1:0] REG_IRQ_EN  = 5'h04;
    localparam logic [RAW-1:0] REG_ONOFF   = 5'h08;
    localparam logic [RAW-1:0] REG_CE_ADDR = 5'h0C;
    localparam logic [RAW-1:0] REG_CHECK_BIT_FAULT_INJECT  = 5'h10;

    localparam int UE_BIT    = 0;
    localparam int CE_BIT    = 1;
    localparam int ONOFF_BIT = 0;

    localparam logic [1:0]     RESP_OKAY   = 2'h0;
    localparam logic [1:0]     RESP_SLVERR = 2'h2;
    localparam logic [BEW-1:0] BE_FULL     = 4'hF;
    localparam logic [1:0]     STAT_RST    = 2'h0;
    localparam logic [1:0]     IRQ_EN_RST  = 2'h0;
    localparam logic [CW-1:0]  FI_RST      = 7'h00;

    function automatic logic [CW-1:0] ecc_encode(input logic [DW-1:0] d);
        logic [CW-1:0] c;
        c = '0;
        for (int k = 0; k < CW; k++) begin
            c[k] = ^(d & CHK_MASK[k]);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

//--- hw/lmc_ecc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lmc_ecc_if;
    logic [lmc_pkg::DW-1:0] data;
    logic [lmc_pkg::CW-1:0] chk;
    logic [lmc_pkg::DW-1:0] fixed;
    logic                   ce;
    logic                   ue;
    modport ctrl (output data, output chk, input fixed, input ce, input ue);
    modport dec  (input data, input chk, output fixed, output ce, output ue);
endinterface
`default_nettype wire

//--- hw/lmc_ecc_dec.sv
`timescale 1ns/1ns
`default_nettype none
module lmc_ecc_dec (
    lmc_ecc_if.dec e
);
    logic [lmc_pkg::CW-1:0] syn;
    logic [lmc_pkg::CW-1:0] col;
    logic                   hit;
    logic                   one;

    always_comb begin
        syn = e.chk ^ lmc_pkg::ecc_encode(e.data);
        e.fixed = e.data;
        hit = 1'b0;
        col = '0;
        for (int j = 0; j < lmc_pkg::DW; j++) begin
            for (int k = 0; k < lmc_pkg::CW; k++) begin
                col[k] = lmc_pkg::CHK_MASK[k][j];
            end
            if (syn == col) begin
                e.fixed[j] = ~e.data[j];
                hit = 1'b1;
            end
        end
        // single flipped check bit leaves data intact
        one = (syn != '0) && ((syn & (syn - 7'h01)) == '0);
        e.ce = hit | one;
        e.ue = (syn != '0) && !(hit | one);
    end
endmodule // lmc_ecc_dec
`default_nettype wire

//--- hw/lmc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module lmc_ctrl #(
    parameter bit ECC          = 1'b1,
    parameter bit FAULT_INJECT = 1'b1,
    parameter bit STATUS_REGS  = 1'b1,
    parameter bit ONOFF_REG    = 1'b1,
    parameter bit ONOFF_RESET  = 1'b1,
    localparam int BW = ECC ? lmc_pkg::DW + lmc_pkg::CW : lmc_pkg::DW
) (
    input  wire logic                                        core_clk,
    input  wire logic                                        nrst,
    input  wire logic [lmc_pkg::NPORT-1:0]                   m_strobe,
    input  wire logic [lmc_pkg::NPORT-1:0]                   m_write,
    input  wire logic [lmc_pkg::NPORT-1:0][lmc_pkg::AW-1:0]  m_addr,
    input  wire logic [lmc_pkg::NPORT-1:0][lmc_pkg::DW-1:0]  m_wdata,
    input  wire logic [lmc_pkg::NPORT-1:0][lmc_pkg::BEW-1:0] m_be,
    output var  logic [lmc_pkg::NPORT-1:0]                   m_ready,
    output var  logic [lmc_pkg::NPORT-1:0][lmc_pkg::DW-1:0]  m_rdata,
    output var  logic [lmc_pkg::NPORT-1:0]                   m_ue,
    output var  logic [lmc_pkg::NPORT-1:0]                   m_ce,
    output      logic                                        bram_clk,
    output var  logic                                        bram_rst,
    output var  logic                                        bram_en,
    output var  logic [lmc_pkg::BEW-1:0]                     bram_we,
    output var  logic [lmc_pkg::AW-1:0]                      bram_addr,
    output var  logic [BW-1:0]                               bram_wdata,
    input  wire logic [BW-1:0]                               bram_rdata,
    output var  logic                                        irq,
    input  wire logic [lmc_pkg::RAW-1:0]                     s_axi_awaddr,
    input  wire logic                                        s_axi_awvalid,
    output var  logic                                        s_axi_awready,
    input  wire logic [31:0]                                 s_axi_wdata,
    input  wire logic [3:0]                                  s_axi_wstrb,
    input  wire logic                                        s_axi_wvalid,
    output var  logic                                        s_axi_wready,
    output var  logic [1:0]                                  s_axi_bresp,
    output var  logic                                        s_axi_bvalid,
    input  wire logic                                        s_axi_bready,
    input  wire logic [lmc_pkg::RAW-1:0]                     s_axi_araddr,
    input  wire logic                                        s_axi_arvalid,
    output var  logic                                        s_axi_arready,
    output var  logic [31:0]                                 s_axi_rdata,
    output var  logic [1:0]                                  s_axi_rresp,
    output var  logic                                        s_axi_rvalid,
    input  wire logic                                        s_axi_rready
);
    localparam int DW = lmc_pkg::DW;
    localparam int CW = lmc_pkg::CW;
    localparam int NP = lmc_pkg::NPORT;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_RD_WAIT = 3'b010,
        ST_RD_DATA = 3'b100
    } lmc_state_t;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic reg_hit(input logic [lmc_pkg::RAW-1:0] a);
        case (a)
            lmc_pkg::REG_STATUS,
            lmc_pkg::REG_IRQ_EN,
            lmc_pkg::REG_CE_ADDR: reg_hit = STATUS_REGS;
            lmc_pkg::REG_ONOFF:   reg_hit = ONOFF_REG;
            lmc_pkg::REG_CHECK_BIT_FAULT_INJECT:  reg_hit = FAULT_INJECT;
            default:              reg_hit = 1'b0;
        endcase
    endfunction

    function automatic logic [DW-1:0] merge(input logic [DW-1:0] old,
                                            input logic [DW-1:0] nw,
                                            input logic [3:0] be);
        merge = old;
        for (int b = 0; b < lmc_pkg::BEW; b++) begin
            if (be[b]) begin
                merge[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    lmc_state_t                          state, next_state;
    logic [1:0]                          cur, next_cur;
    logic [NP-1:0]                       pend, next_pend;
    logic [NP-1:0]                       q_wr, next_q_wr;
    logic [NP-1:0][lmc_pkg::AW-1:0]      q_addr, next_q_addr;
    logic [NP-1:0][DW-1:0]               q_wdata, next_q_wdata;
    logic [NP-1:0][lmc_pkg::BEW-1:0]     q_be, next_q_be;
    logic [NP-1:0]                       next_m_ready, next_m_ue, next_m_ce;
    logic [NP-1:0][DW-1:0]               next_m_rdata;
    logic                                next_bram_en;
    logic [lmc_pkg::BEW-1:0]             next_bram_we;
    logic [lmc_pkg::AW-1:0]              next_bram_addr;
    logic [BW-1:0]                       next_bram_wdata;
    logic [1:0]                          status, next_status;
    logic [1:0]                          irq_en, next_irq_en;
    logic                                chk_on, next_chk_on;
    logic [lmc_pkg::AW-1:0]              ce_addr, next_ce_addr;
    logic [CW-1:0]                       check_bit_fault_inject, next_check_bit_fault_inject;
    logic                                next_irq;
    logic                                ev_ce, ev_ue, fi_used, checking;
    logic [DW+CW-1:0]                    rd_wide;
    logic [DW-1:0]                       word;
    logic [1:0]                          g;
    logic                                wr_fire, rd_fire;
    logic                                next_awready, next_bvalid;
    logic                                next_arready, next_rvalid;
    logic [1:0]                          next_bresp, next_rresp;
    logic [31:0]                         next_rdata;

    lmc_ecc_if ecc_bus ();

    lmc_ecc_dec u_dec (
        .e (ecc_bus.dec)
    );

    // memory port runs on the core clock
    assign bram_clk = core_clk;
    assign rd_wide = (DW + CW)'(bram_rdata);
    assign ecc_bus.data = rd_wide[DW-1:0];
    assign ecc_bus.chk = rd_wide[DW+CW-1:DW];
    // off means raw data, no flags
    assign checking = ECC && chk_on;

    ////////////////////////////////////////////////////////////////////////
    // memory access sequencing
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_pend = pend;
        next_q_wr = q_wr;
        next_q_addr = q_addr;
        next_q_wdata = q_wdata;
        next_q_be = q_be;
        next_m_ready = '0;
        next_m_ue = '0;
        next_m_ce = '0;
        next_m_rdata = m_rdata;
        next_bram_en = 1'b0;
        next_bram_we = '0;
        next_bram_addr = bram_addr;
        next_bram_wdata = bram_wdata;
        ev_ce = 1'b0;
        ev_ue = 1'b0;
        fi_used = 1'b0;
        g = 2'd3;
        word = checking ? ecc_bus.fixed : ecc_bus.data;
        for (int p = NP - 1; p >= 0; p--) begin
            if (pend[p]) begin
                g = 2'(p);
            end
        end
        case (state)
            ST_IDLE: begin
                if (|pend) begin
                    next_cur = g;
                    next_pend[g] = 1'b0;
                    next_bram_en = 1'b1;
                    next_bram_addr = {q_addr[g][lmc_pkg::AW-1:2], 2'b00};
                    if (q_wr[g] && !(ECC && q_be[g] != lmc_pkg::BE_FULL)) begin
                        next_bram_we = ECC ? lmc_pkg::BE_FULL : q_be[g];
                        next_bram_wdata = BW'({lmc_pkg::ecc_encode(q_wdata[g]) ^ check_bit_fault_inject,
                                               q_wdata[g]});
                        fi_used = 1'b1;
                        next_m_ready[g] = 1'b1;
                    end else begin
                        next_state = ST_RD_WAIT;
                    end
                end
            end
            ST_RD_WAIT: begin
                next_state = ST_RD_DATA;
            end
            ST_RD_DATA: begin
                next_state = ST_IDLE;
                next_m_ready[cur] = 1'b1;
                ev_ce = checking && ecc_bus.ce;
                ev_ue = checking && ecc_bus.ue;
                next_m_ue[cur] = ev_ue;
                next_m_ce[cur] = ev_ce;
                if (q_wr[cur]) begin
                    // partial write: merge into read word (repaired only when checking is on), recode
                    next_bram_en = 1'b1;
                    next_bram_we = lmc_pkg::BE_FULL;
                    next_bram_wdata = BW'({lmc_pkg::ecc_encode(
                                           merge(word, q_wdata[cur], q_be[cur])) ^ check_bit_fault_inject,
                                           merge(word, q_wdata[cur], q_be[cur])});
                    fi_used = 1'b1;
                end else begin
                    next_m_rdata[cur] = word;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // new request captured after the grant clear
        for (int p = 0; p < NP; p++) begin
            if (m_strobe[p]) begin
                next_pend[p] = 1'b1;
                next_q_wr[p] = m_write[p];
                next_q_addr[p] = m_addr[p];
                next_q_wdata[p] = m_wdata[p];
                next_q_be[p] = m_be[p];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cur <= '0;
            pend <= '0;
            q_wr <= '0;
            q_addr <= '0;
            q_wdata <= '0;
            q_be <= '0;
            m_ready <= '0;
            m_ue <= '0;
            m_ce <= '0;
            m_rdata <= '0;
            bram_en <= 1'b0;
            bram_we <= '0;
            bram_addr <= '0;
            bram_wdata <= '0;
            bram_rst <= 1'b0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            pend <= next_pend;
            q_wr <= next_q_wr;
            q_addr <= next_q_addr;
            q_wdata <= next_q_wdata;
            q_be <= next_q_be;
            m_ready <= next_m_ready;
            m_ue <= next_m_ue;
            m_ce <= next_m_ce;
            m_rdata <= next_m_rdata;
            bram_en <= next_bram_en;
            bram_we <= next_bram_we;
            bram_addr <= next_bram_addr;
            bram_wdata <= next_bram_wdata;
            bram_rst <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file
    assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
    assign rd_fire = s_axi_arready && s_axi_arvalid;

    always_comb begin
        next_status = status;
        next_irq_en = irq_en;
        next_chk_on = chk_on;
        next_ce_addr = ce_addr;
        next_check_bit_fault_inject = check_bit_fault_inject;
        if (fi_used) begin
            next_check_bit_fault_inject = lmc_pkg::FI_RST;
        end
        if (wr_fire && s_axi_wstrb[0] && reg_hit(s_axi_awaddr)) begin
            case (s_axi_awaddr)
                lmc_pkg::REG_STATUS: next_status = status & ~s_axi_wdata[1:0];
                lmc_pkg::REG_IRQ_EN: next_irq_en = s_axi_wdata[1:0];
                lmc_pkg::REG_ONOFF:  next_chk_on = s_axi_wdata[lmc_pkg::ONOFF_BIT];
                lmc_pkg::REG_CHECK_BIT_FAULT_INJECT: next_check_bit_fault_inject = s_axi_wdata[CW-1:0];
                default:             next_chk_on = chk_on;
            endcase
        end
        if (STATUS_REGS && ev_ce && !status[lmc_pkg::CE_BIT]) begin
            next_ce_addr = q_addr[cur];
        end
        if (STATUS_REGS) begin
            next_status[lmc_pkg::CE_BIT] = next_status[lmc_pkg::CE_BIT] | ev_ce;
            next_status[lmc_pkg::UE_BIT] = next_status[lmc_pkg::UE_BIT] | ev_ue;
        end
        next_irq = ECC && STATUS_REGS && |(status & irq_en);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            status <= lmc_pkg::STAT_RST;
            irq_en <= lmc_pkg::IRQ_EN_RST;
            chk_on <= ONOFF_REG ? ONOFF_RESET : 1'b1;
            ce_addr <= '0;
            check_bit_fault_inject <= lmc_pkg::FI_RST;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq_en <= next_irq_en;
            chk_on <= next_chk_on;
            ce_addr <= next_ce_addr;
            check_bit_fault_inject <= next_check_bit_fault_inject;
            irq <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bus handshakes
    always_comb begin
        next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp = reg_hit(s_axi_awaddr) ? lmc_pkg::RESP_OKAY : lmc_pkg::RESP_SLVERR;
        end
        next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = reg_hit(s_axi_araddr) ? lmc_pkg::RESP_OKAY : lmc_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                lmc_pkg::REG_STATUS:  next_rdata = 32'(status);
                lmc_pkg::REG_IRQ_EN:  next_rdata = 32'(irq_en);
                lmc_pkg::REG_ONOFF:   next_rdata = 32'(chk_on);
                lmc_pkg::REG_CE_ADDR: next_rdata = ce_addr;
                lmc_pkg::REG_CHECK_BIT_FAULT_INJECT:  next_rdata = 32'(check_bit_fault_inject);
                default:              next_rdata = '0;
            endcase
            if (!reg_hit(s_axi_araddr)) begin
                next_rdata = '0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lmc_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= lmc_pkg::RESP_OKAY;
            s_axi_rdata <= '0;
        end else begin
            s_axi_awready <= next_awready;
            s_axi_wready <= next_awready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule // lmc_ctrl
`default_nettype wire

//--- test/lmc_ctrl_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lmc_ctrl_monitor (
    input wire logic                        core_clk,
    input wire logic                        nrst,
    input wire logic [lmc_pkg::NPORT-1:0]   m_strobe,
    input wire logic [lmc_pkg::NPORT-1:0]   m_ready,
    input wire logic [lmc_pkg::NPORT-1:0]   m_ue,
    input wire logic [lmc_pkg::NPORT-1:0]   m_ce,
    input wire logic                        bram_rst,
    input wire logic                        bram_en,
    input wire logic [lmc_pkg::BEW-1:0]     bram_we
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    mem_rst_a: assert property (!bram_rst)
        else $error("memory reset output high");
    one_grant_a: assert property ($onehot0(m_ready))
        else $error("two ports answered at once");
    ue_ready_a: assert property (|m_ue |-> (m_ue & ~m_ready) == '0)
        else $error("error response without ready");
    ce_ready_a: assert property (|m_ce |-> (m_ce & ~m_ready) == '0)
        else $error("corrected flag without ready");
    full_word_a: assert property (|bram_we |-> bram_we == lmc_pkg::BE_FULL)
        else $error("partial word stored with check bits");
    ready_cause_a: assert property (|m_ready |-> bram_en || $past(bram_en, 2))
        else $error("ready without memory access");
    top_bound_a: assert property (m_strobe[0] |-> ##[1:8] m_ready[0])
        else $error("top port not served in time");
    top_first_a: assert property (m_strobe[0] && m_strobe[1] |-> (!m_ready[1]) [*2])
        else $error("lower port served first");
endmodule // lmc_ctrl_monitor
bind lmc_ctrl lmc_ctrl_monitor mon_u (.core_clk(core_clk), .nrst(nrst), .m_strobe(m_strobe),
    .m_ready(m_ready), .m_ue(m_ue), .m_ce(m_ce), .bram_rst(bram_rst), .bram_en(bram_en),
    .bram_we(bram_we));
`default_nettype wire

//--- test/lmc_bram_model.sv
`timescale 1ns/1ns
`default_nettype none
module lmc_bram_model (
    input wire logic        clk,
    input wire logic        en,
    input wire logic [3:0]  we,
    input wire logic [31:0] addr,
    input wire logic [38:0] wdata,
    input wire logic [38:0] flip,
    output var logic [38:0] rdata
);
    logic [38:0] mem [0:15];
    logic [38:0] q = '0;
    // clocked by the controller's memory clock
    always @(posedge clk) begin
        if (en && |we) mem[addr[5:2]] <= wdata;
        // output not held between reads, so a late sample shows up
        q <= en ? mem[addr[5:2]] : ~q;
    end
    assign rdata = q ^ flip;
endmodule // lmc_bram_model
`default_nettype wire

//--- test/tb_local_memory_ecc_controller.sv
`timescale 1ns/1ns
`default_nettype none
module tb_local_memory_ecc_controller;
    logic             core_clk, nrst, bram_clk, bram_rst, bram_en, irq;
    logic [3:0]       m_strobe, m_write, m_ready, m_ue, m_ce, bram_we, s_axi_wstrb;
    logic [3:0][31:0] m_addr, m_wdata, m_rdata;
    logic [3:0][3:0]  m_be;
    logic [31:0]      bram_addr, s_axi_wdata, s_axi_rdata;
    logic [38:0]      bram_wdata, bram_rdata, flip;
    logic [4:0]       s_axi_awaddr, s_axi_araddr;
    logic [1:0]       s_axi_bresp, s_axi_rresp;
    logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic             s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int               fail_count, total_checks;
    localparam logic [6:0][31:0] MASKS = {32'h2DA65CB7, 32'hFC000000, 32'h03FFF800,
        32'h03FC07F0, 32'hE3C3C78E, 32'h9B33366D, 32'h56AAAD5B};
    lmc_ctrl #(.ONOFF_RESET(1'b0)) dut_u (.*);
    lmc_bram_model bram_u (.clk(bram_clk), .en(bram_en), .we(bram_we), .addr(bram_addr),
        .wdata(bram_wdata), .flip(flip), .rdata(bram_rdata));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] ecc(input logic [31:0] d);
        for (int k = 0; k < 7; k++) ecc[k] = ^(d & MASKS[k]);
    endfunction
    task automatic chk(input string what, input logic [38:0] exp, input logic [38:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_mem(input int i, input logic [31:0] d, input logic [6:0] fi);
        @(posedge core_clk);
        chk("stored", {ecc(d) ^ fi, d}, bram_u.mem[i]);
    endtask
    task automatic reg_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (int i = 0; i < 20 && s_axi_awready !== 1'b1; i++) @(posedge core_clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        for (int i = 0; i < 20 && s_axi_bvalid !== 1'b1; i++) @(posedge core_clk);
        chk("bresp", 39'(r), 39'(s_axi_bresp));
    endtask
    task automatic reg_rd(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int i = 0; i < 20 && s_axi_arready !== 1'b1; i++) @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        for (int i = 0; i < 20 && s_axi_rvalid !== 1'b1; i++) @(posedge core_clk);
        chk("reg", 39'(exp), 39'(s_axi_rdata));
        chk("rresp", 39'(r), 39'(s_axi_rresp));
    endtask
    task automatic mem_op(input int p, input logic wr, input logic [31:0] a, d,
                          input logic [3:0] be, input logic [31:0] exp, input logic ue, ce);
        m_strobe[p] <= 1'b1;
        m_write[p] <= wr;
        m_addr[p] <= a;
        m_wdata[p] <= d;
        m_be[p] <= be;
        @(posedge core_clk);
        m_strobe[p] <= 1'b0;
        for (int i = 0; i < 20 && m_ready[p] !== 1'b1; i++) @(posedge core_clk);
        chk("ready", 39'h1, 39'(m_ready[p]));
        if (!wr && !ue) chk("rdata", 39'(exp), 39'(m_rdata[p]));
        chk("ue", 39'(ue), 39'(m_ue[p]));
        chk("ce", 39'(ce), 39'(m_ce[p]));
    endtask
    task automatic t_reset();
        reg_rd(lmc_pkg::REG_STATUS, 32'h0, lmc_pkg::RESP_OKAY);
        reg_rd(lmc_pkg::REG_IRQ_EN, 32'h0, lmc_pkg::RESP_OKAY);
        reg_rd(lmc_pkg::REG_ONOFF, 32'h0, lmc_pkg::RESP_OKAY);
        reg_rd(lmc_pkg::REG_CHECK_BIT_FAULT_INJECT, 32'h0, lmc_pkg::RESP_OKAY);
        reg_rd(5'h14, 32'h0, lmc_pkg::RESP_SLVERR);
        chk("irq", 39'h0, 39'(irq));
    endtask
    task automatic t_off();
        mem_op(0, 1'b1, 32'h40, 32'hCAFE0001, 4'hF, 32'h0, 1'b0, 1'b0);
        flip <= 39'h100;
        mem_op(0, 1'b0, 32'h40, 32'h0, 4'hF, 32'hCAFE0101, 1'b0, 1'b0);
        flip <= '0;
        reg_wr(lmc_pkg::REG_ONOFF, 32'h1, lmc_pkg::RESP_OKAY);
        reg_rd(lmc_pkg::REG_ONOFF, 32'h1, lmc_pkg::RESP_OKAY);
        mem_op(0, 1'b0, 32'h40, 32'h0, 4'hF, 32'hCAFE0001, 1'b0, 1'b0);
    endtask
    task automatic t_encode();
        for (int k = 0; k < 32; k++) begin
            mem_op(1, 1'b1, 32'h0, 32'h1 << k, 4'hF, 32'h0, 1'b0, 1'b0);
            chk_mem(0, 32'h1 << k, 7'h00);
        end
    endtask
    task automatic t_inject();
        reg_wr(lmc_pkg::REG_CHECK_BIT_FAULT_INJECT, 32'h10, lmc_pkg::RESP_OKAY);
        mem_op(0, 1'b1, 32'h10, 32'hA5A50F0F, 4'hF, 32'h0, 1'b0, 1'b0);
        chk_mem(4, 32'hA5A50F0F, 7'h10);
        reg_rd(lmc_pkg::REG_CHECK_BIT_FAULT_INJECT, 32'h0, lmc_pkg::RESP_OKAY);
        reg_wr(lmc_pkg::REG_IRQ_EN, 32'h2, lmc_pkg::RESP_OKAY);
        mem_op(0, 1'b0, 32'h10, 32'h0, 4'hF, 32'hA5A50F0F, 1'b0, 1'b1);
        reg_rd(lmc_pkg::REG_STATUS, 32'h2, lmc_pkg::RESP_OKAY);
        reg_rd(lmc_pkg::REG_CE_ADDR, 32'h10, lmc_pkg::RESP_OKAY);
        chk("irq", 39'h1, 39'(irq));
        reg_wr(lmc_pkg::REG_STATUS, 32'h3, lmc_pkg::RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk("irq", 39'h0, 39'(irq));
    endtask
    task automatic t_errors();
        mem_op(2, 1'b1, 32'h30, 32'h12345678, 4'hF, 32'h0, 1'b0, 1'b0);
        flip <= 39'h20;
        mem_op(2, 1'b0, 32'h30, 32'h0, 4'hF, 32'h12345678, 1'b0, 1'b1);
        flip <= 39'h21;
        mem_op(2, 1'b0, 32'h30, 32'h0, 4'hF, 32'h0, 1'b1, 1'b0);
        flip <= '0;
        reg_rd(lmc_pkg::REG_STATUS, 32'h3, lmc_pkg::RESP_OKAY);
        reg_wr(lmc_pkg::REG_STATUS, 32'h3, lmc_pkg::RESP_OKAY);
    endtask
    task automatic t_partial();
        mem_op(3, 1'b1, 32'h20, 32'h11223344, 4'hF, 32'h0, 1'b0, 1'b0);
        mem_op(3, 1'b1, 32'h20, 32'h000000AA, 4'h1, 32'h0, 1'b0, 1'b0);
        chk_mem(8, 32'h112233AA, 7'h00);
        mem_op(3, 1'b0, 32'h20, 32'h0, 4'hF, 32'h112233AA, 1'b0, 1'b0);
    endtask
    task automatic t_prio();
        int n;
        n = 0;
        m_strobe <= 4'hF;
        m_write <= 4'h0;
        m_addr <= {4{32'h20}};
        @(posedge core_clk);
        m_strobe <= 4'h0;
        for (int i = 0; i < 40 && n < 4; i++) begin
            @(posedge core_clk);
            if (m_ready != 4'h0) begin
                chk("grant", 39'(4'h1 << n), 39'(m_ready));
                n++;
            end
        end
        chk("grants", 39'h4, 39'(n));
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
    initial begin
        {nrst, m_strobe, m_write, m_addr, m_wdata, m_be, flip} = '0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr} = '0;
        s_axi_arvalid = 1'b0;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_off();
        t_encode();
        t_inject();
        t_errors();
        t_partial();
        t_prio();
        give_verdict();
    end
endmodule // tb_local_memory_ecc_controller
`default_nettype wire
